// ==== core/scpu_pkg.sv ====
// Constants and types shared by the serial control port and its update logic
package scpu_pkg;
  // Register file shape
  localparam int SCPU_NREG = 8;
  localparam int SCPU_DW = 8;
  localparam int SCPU_AW = 3;
  // Serial framing: one instruction byte, then one data byte
  localparam logic [2:0] SCPU_CNT_LAST = 3'h7;
  localparam logic [2:0] SCPU_CNT_ZERO = 3'h0;
  localparam int SCPU_RD_BIT = 7;
  // Configuration register and its fields
  localparam logic [SCPU_AW-1:0] SCPU_CFG_ADDR = 3'h0;
  localparam int SCPU_CFG_UNIDIR_BIT = 1;
  localparam int SCPU_CFG_INTUPD_BIT = 0;
  // Reset values
  localparam logic [SCPU_DW-1:0] SCPU_REG_RST = 8'h00;
  localparam logic [2:0] SCPU_PROF_RST = 3'h0;
  // System clock divided by four: counter width and the count before the rising edge
  localparam int SCPU_DIV_W = 2;
  localparam logic [SCPU_DIV_W-1:0] SCPU_DIV_TICK = 2'h1;
  localparam logic [SCPU_DIV_W-1:0] SCPU_DIV_ONE = 2'h1;
  localparam logic [SCPU_DIV_W-1:0] SCPU_DIV_RST = 2'h0;
  // Serial state machine, one-hot
  typedef enum logic [2:0] {
    SCPU_ST_INSTR = 3'b001,
    SCPU_ST_WR = 3'b010,
    SCPU_ST_RD = 3'b100
  } scpu_state_t;
endpackage

// ==== core/scpu_upd.sv ====
// Divided clock output and buffer-to-register commit event detection
`timescale 1ns/10ps
module scpu_upd
  import scpu_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Control from the serial port
  input wire logic int_mode_i,
  input wire logic int_req_i,
  // Commit and profile pins
  input wire logic commit_i,
  input wire logic [2:0] prof_i,
  // Results
  output logic sync_clk_o,
  output logic xfer_o,
  output logic [2:0] prof_o,
  output logic commit_o,
  output logic commit_oe_n_o
);
  logic [SCPU_DIV_W-1:0] div_cnt_ff, nxt_div_cnt;
  logic [2:0] prof_ff, nxt_prof;
  logic commit_q_ff, nxt_commit_q;
  logic pend_ff, nxt_pend;
  logic xfer_ff, nxt_xfer;
  logic commit_drv_ff, nxt_commit_drv;
  logic oe_n_ff, nxt_oe_n;
  logic tick;

  // Tick marks the cycle just before the divided clock rises
  assign tick = (div_cnt_ff == SCPU_DIV_TICK);

  // Next-state logic for divider, sampling and strobe
  always_comb begin
    nxt_div_cnt = div_cnt_ff + SCPU_DIV_ONE;
    nxt_prof = prof_ff;
    nxt_commit_q = commit_q_ff;
    nxt_xfer = 1'b0;
    nxt_commit_drv = commit_drv_ff;
    nxt_oe_n = ~int_mode_i;
    // A request arriving on the tick is kept, so set wins over clear
    nxt_pend = int_req_i | (pend_ff & ~tick);
    if (tick) begin
      // Profile and commit pins are only looked at on the divided clock edge
      nxt_prof = prof_i;
      nxt_commit_q = commit_i;
      nxt_commit_drv = pend_ff & int_mode_i;
      if (prof_i != prof_ff) begin
        nxt_xfer = 1'b1;
      end
      if (int_mode_i) begin
        if (pend_ff) begin
          nxt_xfer = 1'b1;
        end
      end else if (commit_i & ~commit_q_ff) begin
        nxt_xfer = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      div_cnt_ff <= SCPU_DIV_RST;
      prof_ff <= SCPU_PROF_RST;
      commit_q_ff <= 1'b0;
      pend_ff <= 1'b0;
      xfer_ff <= 1'b0;
      commit_drv_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      prof_ff <= nxt_prof;
      commit_q_ff <= nxt_commit_q;
      pend_ff <= nxt_pend;
      xfer_ff <= nxt_xfer;
      commit_drv_ff <= nxt_commit_drv;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign sync_clk_o = div_cnt_ff[1];
  assign xfer_o = xfer_ff;
  assign prof_o = prof_ff;
  assign commit_o = commit_drv_ff;
  assign commit_oe_n_o = oe_n_ff;

  AST_DIV4: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(sync_clk_o) |-> ##4 $rose(sync_clk_o))
    else $error("divided clock period is not four cycles");
  AST_ONE_XFER: assert property (@(posedge clock_i) disable iff (srst_i)
    xfer_o |=> !xfer_o [*3])
    else $error("more than one transfer per divided clock period");
  AST_PROF_CHG: assert property (@(posedge clock_i) disable iff (srst_i)
    (tick && prof_i != prof_ff) |=> xfer_o && prof_o == $past(prof_i))
    else $error("profile change did not commit buffers");
  AST_PIN_DIR: assert property (@(posedge clock_i) disable iff (srst_i)
    int_mode_i |=> !commit_oe_n_o)
    else $error("commit pin not driven in internal mode");
  COV_PROF: cover property (@(posedge clock_i) disable iff (srst_i) tick && prof_i != prof_ff);
  COV_INT: cover property (@(posedge clock_i) disable iff (srst_i) $rose(commit_o));
endmodule

// ==== core/scpu_top.sv ====
// Serial control port with buffered registers and commit logic
`timescale 1ns/10ps
module scpu_top
  import scpu_pkg::*;
#(
  parameter int NREG = SCPU_NREG,
  parameter int DW = SCPU_DW
)
(
  // Clock and resets
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic master_reset_i,
  input wire logic port_recover_i,
  // Serial port pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_n_o,
  output logic serial_read_out_o,
  output logic serial_read_out_oe_n_o,
  // Commit and profile pins
  input wire logic commit_i,
  output logic commit_o,
  output logic commit_oe_n_o,
  input wire logic profile_sel_msb_i,
  input wire logic profile_sel_mid_i,
  input wire logic profile_sel_lsb_i,
  output logic sync_clk_o,
  // Active state toward the synthesizer core
  output logic [2:0] active_profile_o,
  output logic [NREG*DW-1:0] active_regs_o
);
  logic rst;
  logic sclk_q_ff, nxt_sclk_q;
  scpu_state_t state_ff, nxt_state;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [DW-1:0] shift_ff, nxt_shift;
  logic [SCPU_AW-1:0] addr_ff, nxt_addr;
  logic wr_ff, nxt_wr;
  logic sdio_o_ff, nxt_sdio_o;
  logic sdio_oe_n_ff, nxt_sdio_oe_n;
  logic sro_ff, nxt_sro;
  logic sro_oe_n_ff, nxt_sro_oe_n;
  logic [NREG-1:0][DW-1:0] wbuf_ff, nxt_wbuf;
  logic [NREG-1:0][DW-1:0] act_ff, nxt_act;
  logic sclk_rise, sclk_fall;
  logic unidir, int_mode;
  logic xfer;
  logic [DW-1:0] shifted_in;

  // Bit counter step, used by every phase of the transfer
  function automatic logic [2:0] cnt_step(input logic [2:0] c);
    cnt_step = (c == SCPU_CNT_LAST) ? SCPU_CNT_ZERO : c + 3'h1;
  endfunction

  // Master reset clears everything, same as the system reset
  assign rst = srst_i | master_reset_i;

  // Serial clock is taken as synchronous, so one stage of history finds its edges
  assign sclk_rise = sclk_i & ~sclk_q_ff;
  assign sclk_fall = ~sclk_i & sclk_q_ff;
  assign shifted_in = {shift_ff[DW-2:0], sdio_i};

  // Configuration is read from the active copy, so a mode change takes effect on commit
  assign unidir = act_ff[SCPU_CFG_ADDR][SCPU_CFG_UNIDIR_BIT];
  assign int_mode = act_ff[SCPU_CFG_ADDR][SCPU_CFG_INTUPD_BIT];

  // Serial transfer state machine
  always_comb begin
    nxt_sclk_q = sclk_i;
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_addr = addr_ff;
    nxt_wr = 1'b0;
    nxt_sdio_o = sdio_o_ff;
    nxt_sdio_oe_n = sdio_oe_n_ff;
    nxt_sro = sro_ff;
    nxt_sro_oe_n = sro_oe_n_ff;
    if (cs_n_i | port_recover_i) begin
      // Deselected or recovering: drop the frame and release both pins
      nxt_state = SCPU_ST_INSTR;
      nxt_cnt = SCPU_CNT_ZERO;
      nxt_sdio_oe_n = 1'b1;
      nxt_sdio_o = 1'b0;
      nxt_sro_oe_n = 1'b1;
      nxt_sro = 1'b0;
    end else begin
      case (state_ff)
        SCPU_ST_INSTR: begin
          if (sclk_rise) begin
            nxt_shift = shifted_in;
            nxt_cnt = cnt_step(cnt_ff);
            if (cnt_ff == SCPU_CNT_LAST) begin
              nxt_addr = shifted_in[SCPU_AW-1:0];
              if (shifted_in[SCPU_RD_BIT]) begin
                nxt_state = SCPU_ST_RD;
                nxt_shift = act_ff[shifted_in[SCPU_AW-1:0]];
              end else begin
                nxt_state = SCPU_ST_WR;
              end
            end
          end
          if (sclk_fall) begin
            // A new instruction follows a read: give the data pin back
            nxt_sdio_oe_n = 1'b1;
            nxt_sro_oe_n = 1'b1;
          end
        end
        SCPU_ST_WR: begin
          if (sclk_rise) begin
            nxt_shift = shifted_in;
            nxt_cnt = cnt_step(cnt_ff);
            if (cnt_ff == SCPU_CNT_LAST) begin
              nxt_wr = 1'b1;
              nxt_state = SCPU_ST_INSTR;
            end
          end
        end
        SCPU_ST_RD: begin
          if (sclk_fall) begin
            // Data pin or separate output, never both
            if (unidir) begin
              nxt_sro = shift_ff[DW-1];
              nxt_sro_oe_n = 1'b0;
              nxt_sdio_oe_n = 1'b1;
            end else begin
              nxt_sdio_o = shift_ff[DW-1];
              nxt_sdio_oe_n = 1'b0;
              nxt_sro_oe_n = 1'b1;
            end
            nxt_cnt = cnt_step(cnt_ff);
            // After the last bit the same register is sent again
            nxt_shift = (cnt_ff == SCPU_CNT_LAST) ? act_ff[addr_ff] : {shift_ff[DW-2:0], 1'b0};
          end
        end
        default: begin
          nxt_state = SCPU_ST_INSTR;
          nxt_cnt = SCPU_CNT_ZERO;
        end
      endcase
    end
  end

  // Serial state registers
  always_ff @(posedge clock_i) begin
    if (rst) begin
      sclk_q_ff <= 1'b0;
      state_ff <= SCPU_ST_INSTR;
      cnt_ff <= SCPU_CNT_ZERO;
      shift_ff <= SCPU_REG_RST;
      addr_ff <= SCPU_CFG_ADDR;
      wr_ff <= 1'b0;
      sdio_o_ff <= 1'b0;
      sdio_oe_n_ff <= 1'b1;
      sro_ff <= 1'b0;
      sro_oe_n_ff <= 1'b1;
    end else begin
      sclk_q_ff <= nxt_sclk_q;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      addr_ff <= nxt_addr;
      wr_ff <= nxt_wr;
      sdio_o_ff <= nxt_sdio_o;
      sdio_oe_n_ff <= nxt_sdio_oe_n;
      sro_ff <= nxt_sro;
      sro_oe_n_ff <= nxt_sro_oe_n;
    end
  end

  // Write buffers fill from the port; active registers load only on a commit event.
  // A write landing in the commit cycle reaches the actives on the next commit.
  always_comb begin
    nxt_wbuf = wbuf_ff;
    nxt_act = act_ff;
    if (wr_ff) begin
      nxt_wbuf[addr_ff] = shift_ff;
    end
    if (xfer) begin
      nxt_act = wbuf_ff;
    end
  end

  // Register file storage
  always_ff @(posedge clock_i) begin
    if (rst) begin
      wbuf_ff <= '0;
      act_ff <= '0;
    end else begin
      wbuf_ff <= nxt_wbuf;
      act_ff <= nxt_act;
    end
  end

  // Divider, profile sampling and commit strobe; host times pins to sync_clk_o
  scpu_upd u_upd (
    .clock_i(clock_i),
    .srst_i(rst),
    .int_mode_i(int_mode),
    .int_req_i(wr_ff & int_mode),
    .commit_i(commit_i),
    .prof_i({profile_sel_msb_i, profile_sel_mid_i, profile_sel_lsb_i}),
    .sync_clk_o(sync_clk_o),
    .xfer_o(xfer),
    .prof_o(active_profile_o),
    .commit_o(commit_o),
    .commit_oe_n_o(commit_oe_n_o)
  );

  assign sdio_o = sdio_o_ff;
  assign sdio_oe_n_o = sdio_oe_n_ff;
  assign serial_read_out_o = sro_ff;
  assign serial_read_out_oe_n_o = sro_oe_n_ff;
  assign active_regs_o = act_ff;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst);

  AST_CS_IDLE: assert property (cs_n_i |=> sdio_oe_n_o && serial_read_out_oe_n_o && state_ff == SCPU_ST_INSTR)
    else $error("port active while deselected");
  AST_RISE_SAMPLE: assert property (
    (!cs_n_i && !port_recover_i && sclk_rise && state_ff == SCPU_ST_WR) |=> shift_ff[0] == $past(sdio_i))
    else $error("write bit not taken on rising edge");
  AST_FALL_DRIVE: assert property (
    (!cs_n_i && !port_recover_i && sclk_fall && state_ff == SCPU_ST_RD && !unidir)
      |=> !sdio_oe_n_o && sdio_o == $past(shift_ff[DW-1]))
    else $error("read bit not driven on falling edge");
  AST_UNIDIR: assert property (
    (!cs_n_i && !port_recover_i && sclk_fall && state_ff == SCPU_ST_RD && unidir)
      |=> sdio_oe_n_o && !serial_read_out_oe_n_o && serial_read_out_o == $past(shift_ff[DW-1]))
    else $error("unidirectional read used the data pin");
  AST_SRO_OFF: assert property (
    (!cs_n_i && !port_recover_i && sclk_fall && state_ff == SCPU_ST_RD && !unidir) |=> serial_read_out_oe_n_o)
    else $error("separate output active in bidirectional mode");
  AST_RECOVER: assert property (port_recover_i |=> state_ff == SCPU_ST_INSTR && cnt_ff == SCPU_CNT_ZERO)
    else $error("port recovery did not reset the frame");
  AST_COMMIT: assert property (xfer |=> act_ff == $past(wbuf_ff))
    else $error("commit did not copy buffers");
  AST_HOLD: assert property (!xfer |=> act_ff == $past(act_ff))
    else $error("active registers changed without a commit");
  AST_WRITE: assert property (wr_ff |=> wbuf_ff[$past(addr_ff)] == $past(shift_ff))
    else $error("written byte not buffered");
  // Own disable term: the shared default one would switch this check off during the master reset itself
  AST_MRST: assert property (@(posedge clock_i) disable iff (srst_i)
    master_reset_i |=> act_ff == '0 && wbuf_ff == '0)
    else $error("master reset left state");

  COV_WRITE: cover property (wr_ff);
  COV_READ: cover property (state_ff == SCPU_ST_RD && sclk_fall && !cs_n_i);
  COV_COMMIT: cover property (xfer);
endmodule

// ==== tb/scpu_host.sv ====
// Host controller model driving the serial control port pins
`timescale 1ns/10ps
module scpu_host (
  // Clock
  input wire logic clock_i,
  // Device drive of the data pins
  input wire logic sdio_o,
  input wire logic sdio_oe_n_o,
  input wire logic serial_read_out_o,
  // Host drive
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdio_line_o
);
  logic host_d;
  logic host_en;
  logic float_d = 1'b0;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    host_d = 1'b0;
    host_en = 1'b1;
  end

  // A released line toggles every cycle, so a missing device drive cannot read as a match
  always @(posedge clock_i) begin
    float_d <= ~float_d;
  end

  // Wire level from both parties' enables
  assign sdio_line_o = !sdio_oe_n_o ? sdio_o : (host_en ? host_d : float_d);

  // One frame: instruction byte then data byte, MSB first, each serial level held two cycles
  task automatic frame(input logic [7:0] ins, input logic [7:0] dat, input logic uni, input logic sel,
                       input int nbits, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    cs_n_o = ~sel;
    host_en = 1'b1;
    for (i = 15; i > 15 - nbits; i--) begin
      // Hand the line over before the first readback fall
      if (i == 7 && ins[7]) begin
        host_en = 1'b0;
      end
      host_d = i > 7 ? ins[i-8] : dat[i];
      sclk_o = 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      // Read data taken at the rise that follows the device's fall
      if (i <= 7) begin
        rd[i] = uni ? serial_read_out_o : sdio_line_o;
      end
      sclk_o = 1'b1;
      repeat (2) @(posedge clock_i);
      #1;
    end
    // A partial frame leaves chip select low, so only recovery or a deselect can realign the port
    if (nbits == 16) begin
      cs_n_o = 1'b1;
    end
    host_en = 1'b1;
    sclk_o = 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask
endmodule

// ==== tb/scpu_tb_top.sv ====
// Self-checking testbench of the serial control port and commit logic
`timescale 1ns/10ps
module scpu_tb_top;
  import scpu_pkg::*;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic master_reset_i = 1'b0;
  logic port_recover_i = 1'b0;
  logic commit_i = 1'b0;
  logic [2:0] prof = 3'h0;
  wire logic cs_n;
  wire logic sclk;
  wire logic sdio_line;
  logic sdio_o;
  logic sdio_oe_n_o;
  logic serial_read_out_o;
  logic serial_read_out_oe_n_o;
  logic commit_o;
  logic commit_oe_n_o;
  logic sync_clk_o;
  logic [2:0] active_profile_o;
  logic [63:0] active_regs_o;
  int n_mismatch = 0;
  int checked = 0;

  // 50 MHz system clock
  always #10 clock_i = ~clock_i;

  scpu_top dut (.clock_i(clock_i), .srst_i(srst_i), .master_reset_i(master_reset_i),
    .port_recover_i(port_recover_i), .cs_n_i(cs_n), .sclk_i(sclk), .sdio_i(sdio_line), .sdio_o(sdio_o),
    .sdio_oe_n_o(sdio_oe_n_o), .serial_read_out_o(serial_read_out_o),
    .serial_read_out_oe_n_o(serial_read_out_oe_n_o), .commit_i(commit_i), .commit_o(commit_o),
    .commit_oe_n_o(commit_oe_n_o), .profile_sel_msb_i(prof[2]), .profile_sel_mid_i(prof[1]),
    .profile_sel_lsb_i(prof[0]), .sync_clk_o(sync_clk_o), .active_profile_o(active_profile_o),
    .active_regs_o(active_regs_o));

  scpu_host host (.clock_i(clock_i), .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o),
    .serial_read_out_o(serial_read_out_o), .cs_n_o(cs_n), .sclk_o(sclk), .sdio_line_o(sdio_line));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // Bounded wait for the next rise of the divided clock
  task automatic wait_rise();
    int n;
    logic prev;
    n = 0;
    prev = sync_clk_o;
    while (!(sync_clk_o === 1'b1 && prev === 1'b0)) begin
      prev = sync_clk_o;
      cyc(1);
      n++;
      if (n > 8) begin
        n_mismatch++;
        $display("mismatch sync_clk_o expected rise seen none");
        wrap_up();
      end
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.frame({5'h00, a}, d, 1'b0, 1'b1, 16, r);
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic uni, input logic [7:0] exp);
    logic [7:0] r;
    host.frame({5'h10, a}, 8'h00, uni, 1'b1, 16, r);
    chk("read data", {56'h0, exp}, {56'h0, r});
  endtask

  // Commit level set up ahead of the divided clock rise, dropped once the copy has landed
  task automatic commit_tick();
    commit_i = 1'b1;
    wait_rise();
    cyc(3);
    commit_i = 1'b0;
  endtask

  task automatic t_reset();
    chk("regs after reset", 64'h0, active_regs_o);
    chk("enables after reset", 64'h7, {61'h0, sdio_oe_n_o, serial_read_out_oe_n_o, commit_oe_n_o});
  endtask

  task automatic t_divider();
    time t0;
    wait_rise();
    t0 = $time;
    wait_rise();
    chk("sync_clk period in cycles", 64'h4, 64'(($time - t0) / 20));
  endtask

  task automatic t_commit();
    wr(3'h3, 8'ha5);
    cyc(4);
    chk("reg3 before commit", 64'h0, active_regs_o);
    commit_i = 1'b1;
    wait_rise();
    cyc(3);
    chk("reg3 after commit", 64'ha5, {56'h0, active_regs_o[31:24]});
    // Held high level must not copy the next write
    wr(3'h3, 8'h5a);
    cyc(8);
    chk("reg3 under held commit", 64'ha5, {56'h0, active_regs_o[31:24]});
    commit_i = 1'b0;
  endtask

  task automatic t_profile();
    logic [2:0] p;
    int k;
    for (k = 0; k < 3; k++) begin
      p = 3'h4 >> k;
      wr(3'h2, 8'h30 + 8'(k));
      prof = p;
      wait_rise();
      cyc(3);
      chk("active profile", {61'h0, p}, {61'h0, active_profile_o});
      chk("reg2 after profile change", 64'h30 + 64'(k), {56'h0, active_regs_o[23:16]});
    end
  endtask

  task automatic t_ignore();
    logic [7:0] r;
    host.frame(8'h03, 8'hff, 1'b0, 1'b0, 16, r);
    commit_tick();
    chk("reg3 after deselected frame", 64'h5a, {56'h0, active_regs_o[31:24]});
  endtask

  task automatic t_modes();
    int n;
    logic seen;
    rd_chk(3'h3, 1'b0, 8'h5a);
    wr(SCPU_CFG_ADDR, 8'h02);
    commit_tick();
    rd_chk(3'h3, 1'b1, 8'h5a);
    chk("sdio enable in unidirectional", 64'h1, {63'h0, sdio_oe_n_o});
    wr(SCPU_CFG_ADDR, 8'h01);
    commit_tick();
    chk("commit pin enable internal", 64'h0, {63'h0, commit_oe_n_o});
    chk("read out enable bidirectional", 64'h1, {63'h0, serial_read_out_oe_n_o});
    wr(3'h4, 8'h77);
    seen = 1'b0;
    for (n = 0; n < 12; n++) begin
      cyc(1);
      if (commit_o === 1'b1) begin
        seen = 1'b1;
      end
    end
    chk("internal commit strobe", 64'h1, {63'h0, seen});
    chk("reg4 after internal commit", 64'h77, {56'h0, active_regs_o[39:32]});
  endtask

  task automatic t_recover();
    logic [7:0] r;
    host.frame(8'h05, 8'h00, 1'b0, 1'b1, 4, r);
    port_recover_i = 1'b1;
    cyc(2);
    port_recover_i = 1'b0;
    wr(3'h5, 8'h3e);
    cyc(12);
    chk("reg5 after recovery", 64'h3e, {56'h0, active_regs_o[47:40]});
    master_reset_i = 1'b1;
    cyc(2);
    chk("regs in master reset", 64'h0, active_regs_o);
    chk("commit enable in master reset", 64'h1, {63'h0, commit_oe_n_o});
    master_reset_i = 1'b0;
  endtask

  // Main sequence
  initial begin
    cyc(6);
    srst_i = 1'b0;
    t_reset();
    t_divider();
    t_commit();
    t_profile();
    t_ignore();
    t_modes();
    t_recover();
    cyc(4);
    wrap_up();
  end
endmodule
